// File: src/dprc_pkg.sv
/*
  shared constants, modes and carriers of the clocked ram block.
  assumes one 10 mhz clock and a plain register port outside.
*/
// Notes on behaviour
// - clock modes legal only with matching memory modes, refused at build.
// - independent mode: each port's registers follow that port alone.
// - independent mode: each port has its own enable and clear.
// - in/out mode: input registers and output registers clocked apart.
// - in/out mode: input and output groups own enable and clear.
// - read/write mode: write side takes data, address, strobe; read side reads.
// - read/write mode: write and read sides own enable and clear.
// - single-port use hosts two independent half-size memories.
// - all inputs registered; write strobe made internally from the clock.
// - output registers may be bypassed per port.
// - dual-port reads may sample on falling edge, output bypassed.
// - same-port read of address being written returns the new word.
// - same-port masked bytes undefined, unmasked bytes new data.
// - mixed-port collision applies when other port writes read address.
// - collision policy picks old word or undefined output.
// - array contents change at the falling clock edge.
// - read edge before the write commit edge returns old data.
`default_nettype none
package dprc_pkg;
  // array geometry
  localparam int AW = 8;
  localparam int BW = 8;
  localparam int NB = 2;
  localparam int DW = NB * BW;
  localparam int CW = 16;
  // register port
  localparam int RAW = 5;
  localparam int RDW = 32;
  localparam logic [RAW-1:0] OFF_CTRL = 5'h00;
  localparam logic [RAW-1:0] OFF_STAT = 5'h04;
  localparam logic [RAW-1:0] OFF_WCNT_A = 5'h08;
  localparam logic [RAW-1:0] OFF_WCNT_B = 5'h0c;
  localparam logic [RAW-1:0] OFF_MODE = 5'h10;
  localparam int CTRL_BYP_A = 0;
  localparam int CTRL_BYP_B = 1;
  localparam int CTRL_POLICY = 2;
  localparam int STAT_MIXED = 0;
  localparam int STAT_DUAL = 1;
  localparam int MODE_CLK = 0;
  localparam int MODE_MEM = 2;
  localparam int MODE_PS_A = 4;
  localparam int MODE_PS_B = 5;
  localparam logic [DW-1:0] UNDEF_FILL = 16'hffff;
  localparam logic [CW-1:0] CNT_ONE = 16'h0001;
  typedef enum logic [1:0] {CM_INDEP, CM_INOUT, CM_RDWR, CM_SINGLE}
    dprc_clk_mode_t;
  typedef enum logic [1:0] {MM_TRUE_DP, MM_SIMPLE_DP, MM_SINGLE}
    dprc_mem_mode_t;
  typedef enum logic {KEEP_PRIOR, UNDEFINED_OUTPUT} dprc_policy_t;
  typedef struct packed {
    logic we;
    logic re;
    logic [NB-1:0] be;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dprc_req_t;
  typedef struct packed {
    logic in_cen;
    logic in_clr;
    logic out_cen;
    logic out_clr;
  } dprc_ctl_t;
endpackage
`default_nettype wire

// File: src/dprc_mem.sv
/*
  two-port array with registered inputs, falling-edge commit and
  read data register per port. assumes gated requests from the top.
*/
`default_nettype none
module dprc_mem #(
  parameter int DEPTH = 2 ** dprc_pkg::AW,
  parameter logic [1:0] NEG_RD = 2'b00
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // requests and group controls, index 0 is port a
  input wire dprc_pkg::dprc_req_t [1:0] i_req,
  input wire logic [1:0] i_cen,
  input wire logic [1:0] i_clr,
  input wire dprc_pkg::dprc_policy_t i_policy,
  // read data
  output logic [1:0][dprc_pkg::DW-1:0] o_q
);
  if (DEPTH < 2 || DEPTH > 2 ** dprc_pkg::AW) begin : g_bad_depth
    $error("dprc_mem: depth out of range");
  end

  logic [dprc_pkg::DW-1:0] mem [DEPTH];
  dprc_pkg::dprc_req_t wr_reg [2];
  logic [dprc_pkg::DW-1:0] q_reg [2];
  logic [dprc_pkg::DW-1:0] rd_next [2];

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int O = 1 - p;
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        wr_reg[p] <= '0;
      end else if (i_clr[p]) begin
        wr_reg[p] <= '0;
      end else if (i_cen[p]) begin
        wr_reg[p] <= i_req[p];
      end else begin
        wr_reg[p].we <= 1'b0;
      end
    end

    always_comb begin
      logic own;
      logic oth;
      logic [dprc_pkg::DW-1:0] nd;
      logic [dprc_pkg::NB-1:0] nbe;
      own = 1'b0;
      oth = 1'b0;
      nd = i_req[p].wdata;
      nbe = i_req[p].be;
      rd_next[p] = mem[i_req[p].addr];
      if (NEG_RD[p]) begin
        own = wr_reg[p].we && wr_reg[p].addr == i_req[p].addr;
        oth = wr_reg[O].we && wr_reg[O].addr == i_req[p].addr;
        nd = wr_reg[p].wdata;
        nbe = wr_reg[p].be;
      end else begin
        own = i_req[p].we;
        oth = i_cen[O] && i_req[O].we && i_req[O].addr == i_req[p].addr;
      end
      if (own) begin
        for (int b = 0; b < dprc_pkg::NB; b++) begin
          rd_next[p][b*dprc_pkg::BW +: dprc_pkg::BW] = nbe[b] ?
            nd[b*dprc_pkg::BW +: dprc_pkg::BW] :
            dprc_pkg::UNDEF_FILL[b*dprc_pkg::BW +: dprc_pkg::BW];
        end
      end else if (oth && i_policy == dprc_pkg::UNDEFINED_OUTPUT) begin
        rd_next[p] = dprc_pkg::UNDEF_FILL;
      end
    end

    if (NEG_RD[p]) begin : g_neg
      always_ff @(negedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          q_reg[p] <= '0;
        end else if (i_clr[p]) begin
          q_reg[p] <= '0;
        end else if (i_cen[p] && i_req[p].re) begin
          q_reg[p] <= rd_next[p];
        end
      end
    end else begin : g_pos
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          q_reg[p] <= '0;
        end else if (i_clr[p]) begin
          q_reg[p] <= '0;
        end else if (i_cen[p] && i_req[p].re) begin
          q_reg[p] <= rd_next[p];
        end
      end
    end
    assign o_q[p] = q_reg[p];
  end

  // commit on the falling edge; port b lands last on a shared address
  always_ff @(negedge i_clk) begin
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < dprc_pkg::NB; b++) begin
        if (wr_reg[p].we && wr_reg[p].be[b]) begin
          mem[wr_reg[p].addr][b*dprc_pkg::BW +: dprc_pkg::BW] <=
            wr_reg[p].wdata[b*dprc_pkg::BW +: dprc_pkg::BW];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: src/dprc_oreg.sv
/*
  data output register group of one port with bypass.
  assumes enable and clear already mapped to the group.
*/
`default_nettype none
module dprc_oreg (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // group controls
  input wire logic i_cen,
  input wire logic i_clr,
  input wire logic i_bypass,
  // data
  input wire logic [dprc_pkg::DW-1:0] i_d,
  output logic [dprc_pkg::DW-1:0] o_q
);
  typedef struct packed {
    logic [dprc_pkg::DW-1:0] q;
  } dprc_oreg_st_t;

  dprc_oreg_st_t st_reg;
  dprc_oreg_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (i_clr) begin
      st_next.q = '0;
    end else if (i_cen) begin
      st_next.q = i_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = i_bypass ? i_d : st_reg.q;
endmodule
`default_nettype wire

// File: src/dprc_top.sv
/*
  clocked dual-port ram block: clock mode mapping of enables and
  clears, collision status and a small register port.
  assumes synchronous inputs and one 10 mhz clock.
*/
// The address map and the strobed register port were left to the implementer.
`default_nettype none
module dprc_top #(
  parameter dprc_pkg::dprc_clk_mode_t CLK_MODE = dprc_pkg::CM_INDEP,
  parameter dprc_pkg::dprc_mem_mode_t MEM_MODE = dprc_pkg::MM_TRUE_DP,
  parameter logic PSEUDO_A = 1'b0,
  parameter logic PSEUDO_B = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [dprc_pkg::RAW-1:0] i_reg_addr,
  input wire logic [dprc_pkg::RDW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [dprc_pkg::RDW-1:0] o_reg_rdata,
  // port a
  input wire dprc_pkg::dprc_req_t i_a_req,
  input wire dprc_pkg::dprc_ctl_t i_a_ctl,
  output logic [dprc_pkg::DW-1:0] o_a_rdata,
  // port b
  input wire dprc_pkg::dprc_req_t i_b_req,
  input wire dprc_pkg::dprc_ctl_t i_b_ctl,
  output logic [dprc_pkg::DW-1:0] o_b_rdata
);
  typedef struct packed {
    logic byp_a;
    logic byp_b;
    dprc_pkg::dprc_policy_t policy;
    logic seen_mixed;
    logic seen_dual;
    logic [dprc_pkg::CW-1:0] wcnt_a;
    logic [dprc_pkg::CW-1:0] wcnt_b;
    logic [dprc_pkg::RDW-1:0] rdata;
  } dprc_top_st_t;

  // build-time legality of clock mode against memory mode
  localparam logic MODE_OK =
    (CLK_MODE == dprc_pkg::CM_INDEP && MEM_MODE == dprc_pkg::MM_TRUE_DP) ||
    (CLK_MODE == dprc_pkg::CM_INOUT && MEM_MODE != dprc_pkg::MM_SINGLE) ||
    (CLK_MODE == dprc_pkg::CM_RDWR && MEM_MODE == dprc_pkg::MM_SIMPLE_DP) ||
    (CLK_MODE == dprc_pkg::CM_SINGLE && MEM_MODE == dprc_pkg::MM_SINGLE);

  if (!MODE_OK) begin : g_bad_mode
    $error("dprc_top: clock mode not allowed with memory mode");
  end

  if ((PSEUDO_A || PSEUDO_B) && MEM_MODE == dprc_pkg::MM_SINGLE)
  begin : g_bad_pseudo
    $error("dprc_top: falling-edge read needs a dual-port mode");
  end

  localparam logic SIMPLE = MEM_MODE == dprc_pkg::MM_SIMPLE_DP;
  localparam logic [1:0] NEG_RD = {PSEUDO_B, PSEUDO_A};

  dprc_pkg::dprc_req_t [1:0] req_in;
  dprc_pkg::dprc_req_t [1:0] req_g;
  dprc_pkg::dprc_ctl_t [1:0] ctl_in;
  dprc_pkg::dprc_ctl_t [1:0] ctl_g;
  logic [1:0] in_cen;
  logic [1:0] in_clr;
  logic [1:0][dprc_pkg::DW-1:0] mem_q;
  logic [1:0] wr_go;
  logic [1:0] rd_go;
  logic addr_eq;
  logic hit_mixed;
  logic hit_dual;
  logic byp_a;
  logic byp_b;
  dprc_top_st_t st_reg;
  dprc_top_st_t st_next;

  assign req_in[0] = i_a_req;
  assign req_in[1] = i_b_req;
  assign ctl_in[0] = i_a_ctl;
  assign ctl_in[1] = i_b_ctl;

  // map the user enables and clears onto the register groups
  always_comb begin
    req_g = req_in;
    ctl_g = ctl_in;
    unique case (CLK_MODE)
      dprc_pkg::CM_INDEP: begin
        // one clock per port: output group follows the port
        for (int p = 0; p < 2; p++) begin
          ctl_g[p].out_cen = ctl_in[p].in_cen;
          ctl_g[p].out_clr = ctl_in[p].in_clr;
        end
      end
      dprc_pkg::CM_INOUT: begin
        // input and output groups keep their own controls
        ctl_g = ctl_in;
        if (SIMPLE) begin
          req_g[0].re = 1'b0;
          req_g[1].we = 1'b0;
        end
      end
      dprc_pkg::CM_RDWR: begin
        // port a is the write side, port b the read side
        req_g[0].re = 1'b0;
        req_g[1].we = 1'b0;
        ctl_g[0].out_cen = 1'b0;
        ctl_g[0].out_clr = ctl_in[0].in_clr;
        ctl_g[1].out_cen = ctl_in[1].in_cen;
        ctl_g[1].out_clr = ctl_in[1].in_clr;
      end
      dprc_pkg::CM_SINGLE: begin
        // two independent memories, one per half of the array
        for (int p = 0; p < 2; p++) begin
          req_g[p].addr[dprc_pkg::AW-1] = p[0];
          ctl_g[p].out_cen = ctl_in[p].in_cen;
          ctl_g[p].out_clr = ctl_in[p].in_clr;
        end
      end
    endcase
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      in_cen[p] = ctl_g[p].in_cen;
      in_clr[p] = ctl_g[p].in_clr;
      wr_go[p] = in_cen[p] && !in_clr[p] && req_g[p].we;
      rd_go[p] = in_cen[p] && !in_clr[p] && req_g[p].re;
    end
  end

  // cross-port events seen in the same cycle
  assign addr_eq = req_g[0].addr == req_g[1].addr;
  assign hit_mixed = addr_eq && MEM_MODE != dprc_pkg::MM_SINGLE &&
    ((wr_go[0] && rd_go[1]) || (wr_go[1] && rd_go[0]));
  assign hit_dual = addr_eq && wr_go[0] && wr_go[1];

  // falling-edge read ports always bypass their output register
  assign byp_a = st_reg.byp_a || PSEUDO_A;
  assign byp_b = st_reg.byp_b || PSEUDO_B;

  // register port and status
  always_comb begin
    st_next = st_reg;
    st_next.rdata = '0;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        dprc_pkg::OFF_CTRL: begin
          st_next.byp_a = i_reg_wdata[dprc_pkg::CTRL_BYP_A];
          st_next.byp_b = i_reg_wdata[dprc_pkg::CTRL_BYP_B];
          st_next.policy = dprc_pkg::dprc_policy_t'(
            i_reg_wdata[dprc_pkg::CTRL_POLICY]);
        end
        dprc_pkg::OFF_STAT: begin
          if (i_reg_wdata[dprc_pkg::STAT_MIXED]) begin
            st_next.seen_mixed = 1'b0;
          end
          if (i_reg_wdata[dprc_pkg::STAT_DUAL]) begin
            st_next.seen_dual = 1'b0;
          end
        end
        dprc_pkg::OFF_WCNT_A: begin
          st_next.wcnt_a = '0;
        end
        dprc_pkg::OFF_WCNT_B: begin
          st_next.wcnt_b = '0;
        end
        default: begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    if (hit_mixed) begin
      st_next.seen_mixed = 1'b1;
    end
    if (hit_dual) begin
      st_next.seen_dual = 1'b1;
    end
    if (wr_go[0]) begin
      st_next.wcnt_a = st_next.wcnt_a + dprc_pkg::CNT_ONE;
    end
    if (wr_go[1]) begin
      st_next.wcnt_b = st_next.wcnt_b + dprc_pkg::CNT_ONE;
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        dprc_pkg::OFF_CTRL: begin
          st_next.rdata[dprc_pkg::CTRL_BYP_A] = st_reg.byp_a;
          st_next.rdata[dprc_pkg::CTRL_BYP_B] = st_reg.byp_b;
          st_next.rdata[dprc_pkg::CTRL_POLICY] = st_reg.policy;
        end
        dprc_pkg::OFF_STAT: begin
          st_next.rdata[dprc_pkg::STAT_MIXED] = st_reg.seen_mixed;
          st_next.rdata[dprc_pkg::STAT_DUAL] = st_reg.seen_dual;
        end
        dprc_pkg::OFF_WCNT_A: begin
          st_next.rdata[dprc_pkg::CW-1:0] = st_reg.wcnt_a;
        end
        dprc_pkg::OFF_WCNT_B: begin
          st_next.rdata[dprc_pkg::CW-1:0] = st_reg.wcnt_b;
        end
        dprc_pkg::OFF_MODE: begin
          st_next.rdata[dprc_pkg::MODE_CLK +: 2] = CLK_MODE;
          st_next.rdata[dprc_pkg::MODE_MEM +: 2] = MEM_MODE;
          st_next.rdata[dprc_pkg::MODE_PS_A] = PSEUDO_A;
          st_next.rdata[dprc_pkg::MODE_PS_B] = PSEUDO_B;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_reg_rdata = st_reg.rdata;

  // array with input registers, commit and read register
  dprc_mem #(
    .DEPTH(2 ** dprc_pkg::AW),
    .NEG_RD(NEG_RD)
  ) u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_req(req_g),
    .i_cen(in_cen),
    .i_clr(in_clr),
    .i_policy(st_reg.policy),
    .o_q(mem_q)
  );

  // output register group, port a
  dprc_oreg u_oreg_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_cen(ctl_g[0].out_cen),
    .i_clr(ctl_g[0].out_clr),
    .i_bypass(byp_a),
    .i_d(mem_q[0]),
    .o_q(o_a_rdata)
  );

  // output register group, port b
  dprc_oreg u_oreg_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_cen(ctl_g[1].out_cen),
    .i_clr(ctl_g[1].out_clr),
    .i_bypass(byp_b),
    .i_d(mem_q[1]),
    .o_q(o_b_rdata)
  );
endmodule
`default_nettype wire

// File: bench/dprc_top_asserts.sv
/*
  port assertions of the clocked ram block.
  assumes the default independent clocking build with rising-edge reads.
*/
`default_nettype none
module dprc_top_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [dprc_pkg::RAW-1:0] i_reg_addr,
  input wire logic [dprc_pkg::RDW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [dprc_pkg::RDW-1:0] o_reg_rdata,
  // ports a and b
  input wire dprc_pkg::dprc_req_t i_a_req,
  input wire dprc_pkg::dprc_ctl_t i_a_ctl,
  input wire logic [dprc_pkg::DW-1:0] o_a_rdata,
  input wire dprc_pkg::dprc_req_t i_b_req,
  input wire dprc_pkg::dprc_ctl_t i_b_ctl,
  input wire logic [dprc_pkg::DW-1:0] o_b_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] ctl_reg;
  logic go_a;
  logic go_b;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // shadow of bypass and policy bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_reg <= 3'h0;
    end else if (i_reg_wr && i_reg_addr == dprc_pkg::OFF_CTRL) begin
      ctl_reg <= i_reg_wdata[2:0];
    end
  end
  assign go_a = i_a_ctl.in_cen && !i_a_ctl.in_clr && !i_reg_wr;
  assign go_b = i_b_ctl.in_cen && !i_b_ctl.in_clr && !i_reg_wr;
  AST_CTRL_READBACK: assert property (
    i_reg_rd && i_reg_addr == dprc_pkg::OFF_CTRL
    |=> o_reg_rdata == {29'h0, ctl_reg}) else $error("control readback wrong");
  AST_RDATA_ONE_CYCLE: assert property (
    i_reg_rd ##1 !i_reg_rd |=> o_reg_rdata == 32'h0)
    else $error("register read data stood too long");
  AST_HOLD_A: assert property (
    !i_a_ctl.in_cen && !i_a_ctl.in_clr && !i_reg_wr |=> $stable(o_a_rdata))
    else $error("port a output moved while disabled");
  AST_CLR_A: assert property (
    i_a_ctl.in_cen && i_a_ctl.in_clr |=> o_a_rdata == 16'h0000)
    else $error("port a clear missed");
  AST_CLR_ISOLATED: assert property (
    i_a_ctl.in_clr && !i_b_ctl.in_cen && !i_b_ctl.in_clr && !i_reg_wr
    |=> $stable(o_b_rdata)) else $error("port a clear reached port b");
  AST_SAME_PORT_NEW: assert property (
    ctl_reg[0] && go_a && i_a_req.we && i_a_req.re && i_a_req.be == 2'h3
    |=> o_a_rdata == $past(i_a_req.wdata)) else $error("new word not shown");
  AST_MASKED_BYTE: assert property (
    ctl_reg[0] && go_a && i_a_req.we && i_a_req.re && i_a_req.be == 2'h1
    |=> o_a_rdata == ($past(i_a_req.wdata) | 16'hff00))
    else $error("masked byte read wrong");
  AST_MIXED_UNDEF: assert property (
    ctl_reg[1] && ctl_reg[2] && go_b && i_b_req.re && !i_b_req.we && go_a
    && i_a_req.we && i_a_req.be != 2'h0 && i_a_req.addr == i_b_req.addr
    |=> o_b_rdata == dprc_pkg::UNDEF_FILL) else $error("collision fill wrong");
  AST_REG_OUT_LAG: assert property (
    !ctl_reg[0] && go_a && i_a_req.we && i_a_req.re && i_a_req.be == 2'h3
    ##1 go_a |=> o_a_rdata == $past(i_a_req.wdata, 2))
    else $error("registered output lag wrong");
endmodule
bind dprc_top dprc_top_asserts dprc_top_asserts_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_a_req(i_a_req), .i_a_ctl(i_a_ctl),
  .o_a_rdata(o_a_rdata), .i_b_req(i_b_req), .i_b_ctl(i_b_ctl),
  .o_b_rdata(o_b_rdata));
`default_nettype wire

// File: bench/dprc_user.sv
/*
  user logic on port b of the ram block.
  assumes the bench hands it requests just after the rising edge.
*/
`default_nettype none
module dprc_user (
  // wishes of the bench and port a traffic
  input wire dprc_pkg::dprc_req_t i_want,
  input wire dprc_pkg::dprc_req_t i_a_req,
  // port b drive
  output var dprc_pkg::dprc_req_t o_req
);
  timeunit 1ns;
  timeprecision 100ps;
  always_comb begin
    o_req = i_want;
    // never write the word that port a writes
    if (i_want.we && i_a_req.we && i_want.addr == i_a_req.addr) begin
      o_req.we = 1'h0;
    end
    // idle lines carry no stale value
    if (!o_req.we && !o_req.re) begin
      o_req.addr = ~i_want.addr;
      o_req.wdata = ~i_want.wdata;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
/*
  self-checking bench of the clocked ram block.
  assumes the default independent clocking build.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    dprc_pkg::dprc_req_t a;
    dprc_pkg::dprc_ctl_t ac;
    dprc_pkg::dprc_req_t b;
    logic [15:0] qa;
    logic [15:0] qb;
  } dprc_row_t;
  logic clk;
  logic rst;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  dprc_pkg::dprc_req_t a_req;
  dprc_pkg::dprc_req_t b_want;
  dprc_pkg::dprc_req_t b_req;
  dprc_pkg::dprc_ctl_t a_ctl;
  dprc_pkg::dprc_ctl_t b_ctl;
  logic [15:0] a_q;
  logic [15:0] b_q;
  int error_cnt;
  int samples_checked;
  int cyc;
  dprc_row_t rows [8];
  dprc_top dprc_top_inst (.i_clk(clk), .i_rst(rst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_a_req(a_req), .i_a_ctl(a_ctl),
    .o_a_rdata(a_q), .i_b_req(b_req), .i_b_ctl(b_ctl), .o_b_rdata(b_q));
  dprc_user dprc_user_inst (.i_want(b_want), .i_a_req(a_req), .o_req(b_req));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_write(input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic reg_read(input logic [4:0] ad, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  // each row is taken at the edge after it is driven
  task automatic run_rows(input int lo, input int hi);
    // reads land on rising edges only, half a period off any commit
    for (int i = lo; i <= hi + 1; i++) begin
      @(posedge clk);
      a_req <= (i <= hi) ? rows[i].a : 28'h0;
      a_ctl <= (i <= hi) ? rows[i].ac : 4'ha;
      b_want <= (i <= hi) ? rows[i].b : 28'h0;
      #1;
      if (i > lo) begin
        chk("a_rdata", rows[i-1].qa, a_q);
        chk("b_rdata", rows[i-1].qb, b_q);
      end
    end
  endtask
  initial begin
    // request nibble is we, re, be
    rows[0] = '{28'hf101234, 4'ha, 28'h0, 16'h1234, 16'h0000};
    rows[1] = '{28'hd20abcd, 4'ha, 28'h4100000, 16'hffcd, 16'h1234};
    rows[2] = '{28'hb105555, 4'ha, 28'h4100000, 16'hffcd, 16'h1234};
    rows[3] = '{28'h0, 4'ha, 28'h4100000, 16'hffcd, 16'h5555};
    rows[4] = '{28'hb106666, 4'ha, 28'h4100000, 16'hffcd, 16'hffff};
    rows[5] = '{28'hf107777, 4'h2, 28'h4100000, 16'hffcd, 16'h6666};
    rows[6] = '{28'h4400000, 4'ha, 28'he400f0f, 16'hffff, 16'h0fff};
    // the disabled write of row 5 must not have reached the array
    rows[7] = '{28'h4100000, 4'ha, 28'h0, 16'h6666, 16'h0fff};
    rst = 1'h1;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    a_req = 28'h0;
    b_want = 28'h0;
    a_ctl = 4'ha;
    b_ctl = 4'ha;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    reg_write(dprc_pkg::OFF_CTRL, 32'h3);
    run_rows(0, 3);
    reg_write(dprc_pkg::OFF_CTRL, 32'h7);
    run_rows(4, 7);
    reg_read(dprc_pkg::OFF_CTRL, 32'h7);
    reg_read(dprc_pkg::OFF_STAT, 32'h1);
    reg_read(dprc_pkg::OFF_WCNT_A, 32'h4);
    reg_read(dprc_pkg::OFF_WCNT_B, 32'h1);
    reg_read(dprc_pkg::OFF_MODE, 32'h0);
    reg_read(5'h14, 32'h0);
    // write-one clears the flag, any write clears a counter
    reg_write(dprc_pkg::OFF_STAT, 32'h1);
    reg_read(dprc_pkg::OFF_STAT, 32'h0);
    reg_write(dprc_pkg::OFF_WCNT_A, 32'h0);
    reg_read(dprc_pkg::OFF_WCNT_A, 32'h0);
    // registered outputs add one edge
    reg_write(dprc_pkg::OFF_CTRL, 32'h0);
    @(posedge clk);
    a_req <= 28'hf112468;
    @(posedge clk);
    a_req <= 28'h0;
    @(posedge clk);
    #1;
    chk("a_reg_out", 32'h2468, a_q);
    // clear one port while the other is disabled
    @(posedge clk);
    a_ctl <= 4'hc;
    b_ctl <= 4'h0;
    @(posedge clk);
    a_ctl <= 4'ha;
    b_ctl <= 4'ha;
    #1;
    chk("a_cleared", 32'h0, a_q);
    chk("b_kept", 32'h0fff, b_q);
    @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk("a_after_reset", 32'h0, a_q);
    chk("b_after_reset", 32'h0, b_q);
    reg_read(dprc_pkg::OFF_CTRL, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
